/* logic_analyzer_trigger_unit.sv */
module logic_analyzer_trigger_unit
  import trig_unit_pkg::*;
#(
  parameter bit CAPTURE_FALLING = 1'b0,
  parameter int NUM_PORTS       = 2,
  parameter int PORT_WIDTH  [MAX_PORTS] = '{default: 8},
  parameter int PORT_UNITS  [MAX_PORTS] = '{default: 1},
  parameter int PORT_TYPE   [MAX_PORTS] = '{default: TYPE_BASIC},
  parameter int PORT_CNT_W  [MAX_PORTS] = '{default: 0},
  parameter bit SEQ_ENABLE      = 1'b1,
  parameter bit TRIG_OUT_ENABLE = 1'b1
) (
  // clock and reset
  input  wire logic                       clock_in,
  input  wire logic                       reset_n_in,
  // trigger buses, port 0 in the low bits
  input  wire logic [total_width()-1:0]   trigger_input_bus_in,
  // serial configuration
  input  wire logic                       config_data_in,
  input  wire logic                       config_shift_in,
  input  wire logic                       config_update_in,
  // results
  output logic                            trigger_out,
  output logic [total_units()-1:0]        match_event_out,
  output logic [GLB_LVL_W-1:0]            seq_level_out
);

  // ****************************************
  // build-time layout
  // ****************************************
  function automatic int total_width();
    int s;
    s = 0;
    for (int p = 0; p < NUM_PORTS; p++) s += PORT_WIDTH[p];
    return s;
  endfunction

  function automatic int total_units();
    int s;
    s = 0;
    for (int p = 0; p < NUM_PORTS; p++) s += PORT_UNITS[p];
    return s;
  endfunction

  function automatic int port_off(input int p);
    int s;
    s = 0;
    for (int k = 0; k < p; k++) s += PORT_WIDTH[k];
    return s;
  endfunction

  function automatic int unit_port(input int u);
    int s;
    int r;
    s = 0;
    r = 0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (u >= s) r = p;
      s += PORT_UNITS[p];
    end
    return r;
  endfunction

  function automatic int unit_cfg_w(input int u);
    return 4 * PORT_WIDTH[unit_port(u)] + UCFG_FIXED_W;
  endfunction

  function automatic int unit_cfg_off(input int u);
    int s;
    s = 0;
    for (int k = 0; k < u; k++) s += unit_cfg_w(k);
    return s;
  endfunction

  localparam int TOTAL_W   = total_width();
  localparam int NUM_UNITS = total_units();
  localparam int UCFG_TOT  = unit_cfg_off(NUM_UNITS);
  localparam int CFG_TOTAL = UCFG_TOT + GLB_W;

  // ****************************************
  // parameter checks
  // ****************************************
  if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS) begin : ports_chk
    $error("number of trigger buses must be 1 to 16");
  end
  if (NUM_UNITS > MAX_UNITS) begin : units_chk
    $error("total match units exceed 16");
  end
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk
    if (PORT_WIDTH[p] < 1 || PORT_WIDTH[p] > MAX_WIDTH) begin : w_chk
      $error("trigger bus width must be 1 to 256");
    end
    if (PORT_UNITS[p] < 1 || PORT_UNITS[p] > MAX_UNITS) begin : u_chk
      $error("match units per bus must be 1 to 16");
    end
    if (PORT_TYPE[p] < TYPE_BASIC || PORT_TYPE[p] > TYPE_RANGE_EDGES) begin : t_chk
      $error("unknown comparator type");
    end
    if (PORT_CNT_W[p] < 0 || PORT_CNT_W[p] > MAX_CNT_W) begin : c_chk
      $error("counter width must be 0 to 32");
    end
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [CFG_TOTAL-1:0] cfg_shift;
    logic [CFG_TOTAL-1:0] cfg_active;
    logic [TOTAL_W-1:0]   samp;
    logic [TOTAL_W-1:0]   prev;
    logic                 cond_raw;
    logic                 cond_shaped;
    logic [GLB_LVL_W-1:0] seq_level;
    logic                 seq_adv;
    logic                 trig;
    logic [3:0]           quiet;
  } state_type;

  state_type s_q;
  state_type s_d;

  // inverting the clock is the cheapest way to move all logic to the other edge
  wire cap_clk = clock_in ^ CAPTURE_FALLING;

  wire [MAX_UNITS-1:0] ev;
  wire                 delayed;
  wire [GLB_W-1:0]     glb = s_q.cfg_active[UCFG_TOT +: GLB_W];
  wire [15:0]          bool_mask = glb[GLB_MASK_POS +: 16];
  wire                 bool_and  = glb[GLB_AND_POS];
  wire [GLB_LVL_W-1:0] last_lvl  = glb[GLB_LVL_POS +: GLB_LVL_W];
  wire                 pulse_mode = glb[GLB_SHAPE_POS];
  wire                 active_low = glb[GLB_POL_POS];
  wire [SEQ_SEL_W-1:0] lvl_sel = glb[GLB_SEQ_POS + SEQ_LVL_W*s_q.seq_level +: SEQ_SEL_W];
  wire                 lvl_contig = glb[GLB_SEQ_POS + SEQ_LVL_W*s_q.seq_level + SEQ_SEL_W];

  // ****************************************
  // match units
  // ****************************************
  for (genvar u = 0; u < MAX_UNITS; u++) begin : g_unit
    if (u < NUM_UNITS) begin : g_on
      localparam int P = unit_port(u);
      localparam int W = PORT_WIDTH[P];
      match_unit #(
        .WIDTH     (W),
        .UNIT_TYPE (PORT_TYPE[P]),
        .CNT_W     (PORT_CNT_W[P])
      ) u_match (
        .clock_in   (cap_clk),
        .reset_n_in (reset_n_in),
        .sample_in  (s_q.samp[port_off(P) +: W]),
        .prev_in    (s_q.prev[port_off(P) +: W]),
        .cfg_in     (s_q.cfg_active[unit_cfg_off(u) +: unit_cfg_w(u)]),
        .clear_in   (config_update_in),
        .event_out  (ev[u])
      );
    end else begin : g_off
      assign ev[u] = 1'b0;
    end
  end

  trig_delay_line #(
    .LEN (DELAY_LEN)
  ) u_delay (
    .clock_in   (cap_clk),
    .reset_n_in (reset_n_in),
    .d_in       (s_q.cond_shaped),
    .q_out      (delayed)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic cond;
    s_d = s_q;
    cond = 1'b0;
    if (config_shift_in) begin
      s_d.cfg_shift = {config_data_in, s_q.cfg_shift[CFG_TOTAL-1:1]};
    end
    if (config_update_in) begin
      s_d.cfg_active = s_q.cfg_shift;
    end
    s_d.samp = trigger_input_bus_in;
    s_d.prev = s_q.samp;
    s_d.seq_adv = 1'b0;
    if (SEQ_ENABLE) begin
      if (config_update_in) begin
        s_d.seq_level = '0;
      end else if (ev[lvl_sel] && (!lvl_contig || s_q.seq_level == '0 || s_q.seq_adv)) begin
        s_d.seq_adv = 1'b1;
        if (s_q.seq_level >= last_lvl) begin
          cond = 1'b1;
          s_d.seq_level = '0;
        end else begin
          s_d.seq_level = s_q.seq_level + 1'b1;
        end
      end else if (lvl_contig && s_q.seq_level != '0 && s_q.seq_adv) begin
        s_d.seq_level = '0;
      end
    end else if (bool_and) begin
      cond = (bool_mask != '0) && (&(ev | ~bool_mask));
    end else begin
      cond = |(ev & bool_mask);
    end
    s_d.cond_raw = cond;
    s_d.cond_shaped = pulse_mode ? (cond && !s_q.cond_raw) : cond;
    s_d.trig = TRIG_OUT_ENABLE && (delayed ^ active_low);
    if (config_update_in) begin
      s_d.quiet = '0;
    end else if (s_q.quiet != 4'hf) begin
      s_d.quiet = s_q.quiet + 4'h1;
    end
  end

  always_ff @(posedge cap_clk or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign trigger_out     = s_q.trig;
  assign match_event_out = ev[NUM_UNITS-1:0];
  assign seq_level_out   = s_q.seq_level;

  // ****************************************
  // checks
  // ****************************************
  out_latency_a: assert property (@(posedge cap_clk) disable iff (!reset_n_in)
    (TRIG_OUT_ENABLE && s_q.quiet >= 4'h9) |->
    trigger_out == ($past(s_q.cond_shaped, 7) ^ active_low))
    else $error("trigger output latency wrong");

  pulse_single_a: assert property (@(posedge cap_clk) disable iff (!reset_n_in)
    (pulse_mode && s_q.quiet >= 4'h2 && s_q.cond_shaped) |=> !s_q.cond_shaped)
    else $error("pulse shape held longer than one cycle");

  level_follow_a: assert property (@(posedge cap_clk) disable iff (!reset_n_in)
    (!pulse_mode && s_q.quiet >= 4'h1) |-> s_q.cond_shaped == s_q.cond_raw)
    else $error("level shape differs from condition");

  seq_bound_a: assert property (@(posedge cap_clk) disable iff (!reset_n_in)
    (SEQ_ENABLE && s_q.quiet >= 4'h1) |-> s_q.seq_level <= last_lvl)
    else $error("sequencer beyond last level");

  seq_wrap_a: assert property (@(posedge cap_clk) disable iff (!reset_n_in)
    (SEQ_ENABLE && s_q.cond_raw) |-> (s_q.seq_level == '0 && s_q.seq_adv))
    else $error("sequencer did not wrap on completion");

  contig_drop_a: assert property (@(posedge cap_clk) disable iff (!reset_n_in)
    (SEQ_ENABLE && !config_update_in && lvl_contig && s_q.seq_level != '0 &&
     s_q.seq_adv && !ev[lvl_sel]) |=> s_q.seq_level == '0)
    else $error("contiguous level kept after a gap");

  bool_and_a: assert property (@(posedge cap_clk) disable iff (!reset_n_in)
    (!SEQ_ENABLE && bool_and && bool_mask != '0 && &(ev | ~bool_mask) &&
     !config_update_in) |=> s_q.cond_raw)
    else $error("and combination missed");

  sample_prev_a: assert property (@(posedge cap_clk) disable iff (!reset_n_in)
    (s_q.quiet >= 4'h2) |-> s_q.prev == $past(trigger_input_bus_in, 2))
    else $error("previous sample not one edge old");

  cfg_hold_a: assert property (@(posedge cap_clk) disable iff (!reset_n_in)
    !config_update_in |=> $stable(s_q.cfg_active))
    else $error("configuration changed without update");

endmodule

/* trig_unit_pkg.sv */
package trig_unit_pkg;

  // ****************************************
  // build-time limits
  // ****************************************
  localparam int MAX_PORTS  = 16;
  localparam int MAX_UNITS  = 16;
  localparam int MAX_WIDTH  = 256;
  localparam int MAX_CNT_W  = 32;
  localparam int MAX_LEVELS = 16;

  // ****************************************
  // timing: inputs sampled at edge 0, trigger output at edge 10
  // ****************************************
  localparam int TRIG_LATENCY = 10;
  localparam int PIPE_STAGES  = 4;
  localparam int DELAY_LEN    = TRIG_LATENCY - PIPE_STAGES;

  // ****************************************
  // comparator types
  // ****************************************
  localparam int TYPE_BASIC          = 0;
  localparam int TYPE_BASIC_EDGES    = 1;
  localparam int TYPE_EXTENDED       = 2;
  localparam int TYPE_EXTENDED_EDGES = 3;
  localparam int TYPE_RANGE          = 4;
  localparam int TYPE_RANGE_EDGES    = 5;

  // ****************************************
  // per-bit value codes
  // ****************************************
  localparam logic [2:0] CODE_LOW  = 3'h0;
  localparam logic [2:0] CODE_HIGH = 3'h1;
  localparam logic [2:0] CODE_DC   = 3'h2;
  localparam logic [2:0] CODE_RISE = 3'h3;
  localparam logic [2:0] CODE_FALL = 3'h4;
  localparam logic [2:0] CODE_ANY  = 3'h5;
  localparam int         CODE_W    = 3;

  // ****************************************
  // match functions
  // ****************************************
  localparam logic [2:0] OP_EQ       = 3'h0;
  localparam logic [2:0] OP_NE       = 3'h1;
  localparam logic [2:0] OP_GT       = 3'h2;
  localparam logic [2:0] OP_GE       = 3'h3;
  localparam logic [2:0] OP_LT       = 3'h4;
  localparam logic [2:0] OP_LE       = 3'h5;
  localparam logic [2:0] OP_IN_RANGE = 3'h6;
  localparam logic [2:0] OP_OUT_RANGE = 3'h7;

  // ****************************************
  // per-unit configuration slice layout
  // ****************************************
  localparam int UCFG_TGT_POS = 0;
  localparam int UCFG_TGT_W   = 32;
  localparam int UCFG_OP_POS  = 32;
  localparam int UCFG_OP_W    = 3;
  localparam int UCFG_UP_POS  = 35;
  localparam int UCFG_FIXED_W = 35;

  // ****************************************
  // global configuration slice layout
  // ****************************************
  localparam int GLB_MASK_POS  = 0;
  localparam int GLB_AND_POS   = 16;
  localparam int GLB_LVL_POS   = 17;
  localparam int GLB_LVL_W     = 4;
  localparam int GLB_SEQ_POS   = 21;
  localparam int SEQ_LVL_W     = 5;
  localparam int SEQ_SEL_W     = 4;
  localparam int GLB_SHAPE_POS = 101;
  localparam int GLB_POL_POS   = 102;
  localparam int GLB_W         = 103;

  function automatic bit type_has_edges(input int t);
    return (t == TYPE_BASIC_EDGES) || (t == TYPE_EXTENDED_EDGES) || (t == TYPE_RANGE_EDGES);
  endfunction

  function automatic bit type_has_mag(input int t);
    return t >= TYPE_EXTENDED;
  endfunction

  function automatic bit type_has_range(input int t);
    return t >= TYPE_RANGE;
  endfunction

endpackage

/* trig_delay_line.sv */
module trig_delay_line
  import trig_unit_pkg::*;
#(
  parameter int LEN = DELAY_LEN
) (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  // data
  input  wire logic d_in,
  output logic      q_out
);

  typedef struct packed {
    logic [LEN-1:0] sr;
  } state_type;

  state_type s_q;
  state_type s_d;

  if (LEN < 1) begin : len_chk
    $error("delay line length must be at least one");
  end

  always_comb begin
    s_d = s_q;
    // the cast drops the oldest bit, which also serves a one-stage line
    s_d.sr = LEN'({s_q.sr, d_in});
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.sr[LEN-1];

  // judged only once the whole line has been filled since reset
  delay_exact_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    $past(reset_n_in, LEN) |-> q_out == $past(d_in, LEN)) else $error("delay line depth wrong");

endmodule

/* match_unit.sv */
module match_unit
  import trig_unit_pkg::*;
#(
  parameter int WIDTH     = 8,
  parameter int UNIT_TYPE = TYPE_BASIC,
  parameter int CNT_W     = 0
) (
  // clock and reset
  input  wire logic                              clock_in,
  input  wire logic                              reset_n_in,
  // samples
  input  wire logic [WIDTH-1:0]                  sample_in,
  input  wire logic [WIDTH-1:0]                  prev_in,
  // configuration
  input  wire logic [4*WIDTH+UCFG_FIXED_W-1:0]   cfg_in,
  input  wire logic                              clear_in,
  // result
  output logic                                   event_out
);

  localparam int  CWI   = (CNT_W == 0) ? 1 : CNT_W;
  localparam bit  EDGES = type_has_edges(UNIT_TYPE);
  localparam bit  MAG   = type_has_mag(UNIT_TYPE);
  localparam bit  RNG   = type_has_range(UNIT_TYPE);
  localparam int  CPOS  = UCFG_UP_POS + WIDTH;

  typedef struct packed {
    logic           hit;
    logic [CWI-1:0] count;
    logic           evt;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic [WIDTH-1:0] bit_ok;
  logic [WIDTH-1:0] edge_bit;
  logic [WIDTH-1:0] mag_mask;
  logic [WIDTH-1:0] val;

  wire [WIDTH-1:0] upper  = cfg_in[UCFG_UP_POS +: WIDTH];
  wire [2:0]       op     = cfg_in[UCFG_OP_POS +: UCFG_OP_W];
  wire [CWI-1:0]   target = cfg_in[UCFG_TGT_POS +: CWI];

  if (WIDTH < 1 || WIDTH > MAX_WIDTH || CNT_W < 0 || CNT_W > MAX_CNT_W) begin : par_chk
    $error("match unit width or counter width out of range");
  end

  // ****************************************
  // per-bit decode
  // ****************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    wire [2:0] c = cfg_in[CPOS + CODE_W*i +: CODE_W];
    // edge codes on a type without edges fall back to ignored bits
    always_comb begin
      edge_bit[i] = EDGES && (c == CODE_RISE || c == CODE_FALL || c == CODE_ANY);
      mag_mask[i] = (c == CODE_LOW) || (c == CODE_HIGH);
      val[i]      = (c == CODE_HIGH);
      case (c)
        CODE_LOW:  bit_ok[i] = !sample_in[i];
        CODE_HIGH: bit_ok[i] = sample_in[i];
        CODE_RISE: bit_ok[i] = !EDGES || (sample_in[i] && !prev_in[i]);
        CODE_FALL: bit_ok[i] = !EDGES || (!sample_in[i] && prev_in[i]);
        CODE_ANY:  bit_ok[i] = !EDGES || (sample_in[i] ^ prev_in[i]);
        default:   bit_ok[i] = 1'b1;
      endcase
    end
  end

  // ****************************************
  // comparison, counter
  // ****************************************
  always_comb begin
    logic             equal;
    logic             edges_ok;
    logic [WIDTH-1:0] sm;
    logic [WIDTH-1:0] um;
    logic             hit;
    logic             reached;
    equal    = &bit_ok;
    edges_ok = &(bit_ok | ~edge_bit);
    sm       = sample_in & mag_mask;
    um       = upper & mag_mask;
    hit      = 1'b0;
    reached  = ({1'b0, s_q.count} + {{CWI{1'b0}}, 1'b1}) >= {1'b0, target};
    case (op)
      OP_EQ:        hit = equal;
      OP_NE:        hit = !equal;
      OP_GT:        hit = MAG && edges_ok && (sm > val);
      OP_GE:        hit = MAG && edges_ok && (sm >= val);
      OP_LT:        hit = MAG && edges_ok && (sm < val);
      OP_LE:        hit = MAG && edges_ok && (sm <= val);
      OP_IN_RANGE:  hit = RNG && edges_ok && (sm >= val) && (sm <= um);
      OP_OUT_RANGE: hit = RNG && edges_ok && !((sm >= val) && (sm <= um));
      default:      hit = 1'b0;
    endcase
    s_d     = s_q;
    s_d.hit = hit;
    // the counter saturates one short of the target, so every later hit still reports
    if (clear_in) begin
      // the hit taken at the update edge was judged against the old pattern
      s_d.hit   = 1'b0;
      s_d.count = '0;
      s_d.evt   = 1'b0;
    end else if (CNT_W == 0) begin
      s_d.evt = s_q.hit;
    end else begin
      s_d.evt = s_q.hit && reached;
      if (s_q.hit && !reached) begin
        s_d.count = CWI'(s_q.count + 1'b1);
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign event_out = s_q.evt;

  event_needs_hit_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    event_out |-> $past(s_q.hit)) else $error("event without a preceding hit");

  count_gate_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (CNT_W != 0 && s_q.hit && !clear_in && s_q.count == '0 && target > 1) |=> !event_out)
    else $error("counter reported before target reached");

endmodule

/* trig_bus_source.sv */
module trig_bus_source #(
  parameter int WIDTH = 8
) (
  // ****************************************
  // stimulus from the bench
  // ****************************************
  input  wire logic [WIDTH-1:0] level_in,
  // ****************************************
  // trigger buses towards the analyzer
  // ****************************************
  output logic      [WIDTH-1:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // user logic drives synchronous levels; the bench changes them at falling edges
  assign bus_out = level_in;
endmodule

/* logic_analyzer_trigger_unit_tb_top.sv */
module logic_analyzer_trigger_unit_tb_top;
  import trig_unit_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // design hookup
  // ****************************************
  localparam int CFG_N = 205;
  logic             clock_in = 1'b0;
  logic             reset_n_in = 1'b0;
  logic [7:0]       level = 8'h00;
  logic [7:0]       bus;
  logic             cfg_data = 1'b0;
  logic             cfg_shift = 1'b0;
  logic             cfg_update = 1'b0;
  logic             trigger_out;
  logic             trig_bool;
  logic             bool_tr = 1'b0;
  logic [1:0]       events;
  logic [3:0]       seq_level;
  logic [CFG_N-1:0] cfg;
  int               errors = 0;
  int               checks_done = 0;

  always #12.5 clock_in = ~clock_in;

  trig_bus_source #(.WIDTH(8)) i_source (.level_in(level), .bus_out(bus));

  logic_analyzer_trigger_unit #(
    .PORT_WIDTH('{default: 4}),
    .PORT_TYPE ('{0: TYPE_RANGE_EDGES, default: TYPE_BASIC}),
    .PORT_CNT_W('{0: 3, default: 0})
  ) i_dut (
    .clock_in            (clock_in),
    .reset_n_in          (reset_n_in),
    .trigger_input_bus_in(bus),
    .config_data_in      (cfg_data),
    .config_shift_in     (cfg_shift),
    .config_update_in    (cfg_update),
    .trigger_out         (trigger_out),
    .match_event_out     (events),
    .seq_level_out       (seq_level)
  );

  // same ports, boolean combination in place of the sequencer
  logic_analyzer_trigger_unit #(
    .PORT_WIDTH('{default: 4}),
    .PORT_TYPE ('{0: TYPE_RANGE_EDGES, default: TYPE_BASIC}),
    .PORT_CNT_W('{0: 3, default: 0}),
    .SEQ_ENABLE(1'b0)
  ) i_dut_bool (
    .clock_in            (clock_in),
    .reset_n_in          (reset_n_in),
    .trigger_input_bus_in(bus),
    .config_data_in      (cfg_data),
    .config_shift_in     (cfg_shift),
    .config_update_in    (cfg_update),
    .trigger_out         (trig_bool),
    .match_event_out     (),
    .seq_level_out       ()
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string name, input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic set_unit(input int u, input logic [31:0] tgt, input logic [2:0] op,
                          input logic [3:0] ub, input logic [11:0] codes);
    cfg[u*51 +: 51] = {codes, ub, op, tgt};
  endtask

  // serial load, bit 0 first, then one update pulse
  task automatic load;
    for (int i = 0; i < CFG_N; i++) begin
      @(negedge clock_in);
      cfg_shift = 1'b1;
      cfg_data = cfg[i];
    end
    @(negedge clock_in);
    cfg_shift = 1'b0;
    cfg_update = 1'b1;
    @(negedge clock_in);
    cfg_update = 1'b0;
    repeat (12) @(negedge clock_in);
  endtask

  // one-cycle stimulus; events seen after edge 2, trigger after edge 10
  task automatic pulse(input logic [7:0] v, input logic [1:0] ev, input logic tr);
    logic [7:0] idle;
    idle = level;
    @(negedge clock_in);
    level = v;
    @(negedge clock_in);
    level = idle;
    @(negedge clock_in);
    @(negedge clock_in);
    check("match_event_out", {2'b00, ev}, {2'b00, events});
    repeat (8) @(negedge clock_in);
    check("trigger_out", {3'b000, tr}, {3'b000, trigger_out});
    check("bool trigger_out", {3'b000, bool_tr}, {3'b000, trig_bool});
  endtask

  task automatic final_report;
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (5) @(negedge clock_in);
    reset_n_in = 1'b1;
    check("reset trigger_out", 4'h0, {3'b000, trigger_out});
    check("reset seq_level_out", 4'h0, seq_level);
    // range unit on port 0, lower bound 2, upper bound 5; port 1 never hits
    cfg = '0;
    set_unit(0, 32'h0, OP_IN_RANGE, 4'h5, {3'h0, 3'h0, 3'h1, 3'h0});
    set_unit(1, 32'h0, OP_NE, 4'h0, {4{3'h2}});
    load;
    pulse(8'h03, 2'b01, 1'b1);
    pulse(8'h06, 2'b00, 1'b0);
    set_unit(0, 32'h0, OP_OUT_RANGE, 4'h5, {3'h0, 3'h0, 3'h1, 3'h0});
    load;
    pulse(8'h05, 2'b00, 1'b0);
    pulse(8'h06, 2'b01, 1'b1);
    // counter target three: only the third hit reports
    set_unit(0, 32'h3, OP_EQ, 4'h0, {3'h0, 3'h0, 3'h1, 3'h1});
    load;
    pulse(8'h03, 2'b00, 1'b0);
    pulse(8'h03, 2'b00, 1'b0);
    pulse(8'h03, 2'b01, 1'b1);
    // transition codes against the previous sample
    set_unit(0, 32'h0, OP_EQ, 4'h0, {3'h2, 3'h2, 3'h2, 3'h3});
    load;
    pulse(8'h01, 2'b01, 1'b1);
    level = 8'h01;
    repeat (12) @(negedge clock_in);
    pulse(8'h01, 2'b00, 1'b0);
    set_unit(0, 32'h0, OP_EQ, 4'h0, {3'h2, 3'h2, 3'h2, 3'h4});
    load;
    pulse(8'h00, 2'b01, 1'b1);
    level = 8'h00;
    // two-level sequence: port 1 pattern 5, then port 0 pattern a
    set_unit(0, 32'h0, OP_EQ, 4'h0, {3'h1, 3'h0, 3'h1, 3'h0});
    set_unit(1, 32'h0, OP_EQ, 4'h0, {3'h0, 3'h1, 3'h0, 3'h1});
    cfg[102 + GLB_LVL_POS +: 4] = 4'h1;
    cfg[102 + GLB_SEQ_POS +: 4] = 4'h1;
    load;
    pulse(8'h50, 2'b10, 1'b0);
    check("seq_level_out", 4'h1, seq_level);
    pulse(8'h0a, 2'b01, 1'b1);
    check("seq_level_out", 4'h0, seq_level);
    // contiguous second level with a gap falls back to level 0
    cfg[102 + GLB_SEQ_POS + 9] = 1'b1;
    cfg[102 + GLB_POL_POS] = 1'b1;
    bool_tr = 1'b1;
    load;
    check("active low idle", 4'h1, {3'b000, trigger_out});
    pulse(8'h50, 2'b10, 1'b1);
    pulse(8'h0a, 2'b01, 1'b1);
    // pulse shape, greater-than on port 0, and of both units in the boolean copy
    set_unit(0, 32'h0, OP_GT, 4'h0, {3'h0, 3'h1, 3'h0, 3'h0});
    cfg[102 + GLB_LVL_POS +: 4] = 4'h0;
    cfg[102 + GLB_SEQ_POS +: 4] = 4'h0;
    cfg[102 + GLB_MASK_POS +: 16] = 16'h0003;
    cfg[102 + GLB_AND_POS] = 1'b1;
    cfg[102 + GLB_SHAPE_POS] = 1'b1;
    cfg[102 + GLB_POL_POS] = 1'b0;
    bool_tr = 1'b0;
    load;
    pulse(8'h06, 2'b01, 1'b1);
    pulse(8'h04, 2'b00, 1'b0);
    bool_tr = 1'b1;
    pulse(8'h56, 2'b11, 1'b1);
    // a held hit gives a single trigger cycle in pulse shape
    level = 8'h06;
    repeat (11) @(negedge clock_in);
    check("pulse trigger_out", 4'h1, {3'b000, trigger_out});
    @(negedge clock_in);
    check("pulse trigger_out", 4'h0, {3'b000, trigger_out});
    final_report;
  end
endmodule
